// ===== src/sse_core.sv
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - nibble exchange swaps file register halves
// - dest 0 writes working register only
// - dest 1 writes file register back
// - minuend greater: carry set, zero clear
// - operands equal: carry set, zero set
// - subtrahend greater: carry, zero clear, wrap
// - literal minus working, into working register
// - literal subtract updates all three flags
module sse_core (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} sse_state_e;

    // 8-bit difference plus flags; carry means no borrow
    // flag bits sit in the order of the flags struct: zero, digit, carry
    function automatic logic [10:0] sse_sub(input logic [7:0] a,
                                            input logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        sse_sub = {(d == 8'h00), (a[3:0] >= b[3:0]), (a >= b), d};
    endfunction : sse_sub

    sse_state_e state_r;
    sse_pkg::sse_instr_s ins_r;
    sse_pkg::sse_flags_s flags_r;
    logic [7:0] work_r;
    logic [6:0] faddr_r;
    logic [7:0] aw_addr_r;
    logic aw_have_r;
    logic [31:0] w_data_r;
    logic w_have_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [1:0] bresp_r;
    logic bvalid_r;
    logic rvalid_r;

    // write decode
    wire busy = (state_r != ST_IDLE);
    // writes wait while an instruction runs, so flags see one writer
    wire wr_go = aw_have_r && w_have_r && !bvalid_r && !busy;
    wire wr_all = (w_data_r[3:0] == 4'hf);
    wire wr_ins = wr_go && (aw_addr_r == sse_pkg::REG_INSTR_OFS);
    wire wr_work = wr_go && (aw_addr_r == sse_pkg::REG_WORK_OFS);
    wire wr_stat = wr_go && (aw_addr_r == sse_pkg::REG_STATUS_OFS);
    wire wr_fadr = wr_go && (aw_addr_r == sse_pkg::REG_FADDR_OFS);
    wire wr_fdat = wr_go && (aw_addr_r == sse_pkg::REG_FDATA_OFS);
    wire wr_hit = wr_ins || wr_work || wr_stat || wr_fadr || wr_fdat;
    wire rd_go = s_axi_arvalid && !rvalid_r;

    // datapath
    wire [7:0] file_q;
    wire is_lit = (ins_r.op == sse_pkg::OP_SUBTRACT_W_FROM_LITERAL);
    wire is_subf = (ins_r.op == sse_pkg::OP_SUBTRACT_W_FROM_FILE);
    wire is_swap = (ins_r.op == sse_pkg::OP_NIBBLE_EXCHANGE_FILE);
    wire is_sub = is_lit || is_subf;
    wire exec = (state_r == ST_EXEC) && (is_sub || is_swap);
    wire [7:0] minuend = is_lit ? ins_r.literal : file_q;
    wire [10:0] sub_res = sse_sub(minuend, work_r);
    wire [7:0] swap_res = {file_q[3:0], file_q[7:4]};
    wire [7:0] result = is_swap ? swap_res : sub_res[7:0];
    // literal form always lands in the working register
    wire to_file = exec && !is_lit && ins_r.dest;
    wire to_work = exec && (is_lit || !ins_r.dest);
    wire mem_we = to_file || wr_fdat;
    wire [6:0] mem_wa = to_file ? ins_r.faddr : faddr_r;
    wire [7:0] mem_wd = to_file ? result : w_data_r[7:0];
    wire [6:0] mem_ra = busy ? ins_r.faddr : faddr_r;

    sse_file_ram sse_file_ram_inst (
        .ref_clk_i(ref_clk_i),
        .we_i(mem_we),
        .waddr_i(mem_wa),
        .wdata_i(mem_wd),
        .raddr_i(mem_ra),
        .rdata_o(file_q)
    );

    // read mux
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb
    begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (s_axi_araddr)
            sse_pkg::REG_INSTR_OFS: rd_mux = 32'(ins_r);
            sse_pkg::REG_WORK_OFS: rd_mux = {24'h00_0000, work_r};
            sse_pkg::REG_STATUS_OFS: rd_mux = {28'h000_0000, busy, flags_r};
            sse_pkg::REG_FADDR_OFS: rd_mux = {25'h000_0000, faddr_r};
            sse_pkg::REG_FDATA_OFS: rd_mux = {24'h00_0000, file_q};
            default: rd_hit = 1'b0;
        endcase
    end

    // axi handshake
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b0;
            rvalid_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            bresp_r <= sse_pkg::RESP_OKAY;
            rresp_r <= sse_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            if (s_axi_awvalid && !aw_have_r)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_have_r)
            begin
                w_have_r <= 1'b1;
                w_data_r <= {28'h000_0000, s_axi_wstrb} == 32'h0 ?
                    32'h0000_0000 : s_axi_wdata;
            end
            if (wr_go)
            begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? sse_pkg::RESP_OKAY : sse_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                bvalid_r <= 1'b0;
            end
            if (rd_go)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= rd_hit ? sse_pkg::RESP_OKAY : sse_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
            begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_have_r;
    assign s_axi_wready = !w_have_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // sequencer: fetch reads the file register, exec writes back
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            state_r <= ST_IDLE;
            ins_r <= '0;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    if (wr_ins)
                    begin
                        ins_r <= sse_pkg::sse_instr_s'(w_data_r[17:0]);
                        state_r <= ST_FETCH;
                    end
                end
                ST_FETCH: state_r <= ST_EXEC;
                ST_EXEC: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            work_r <= sse_pkg::WORK_RST;
            faddr_r <= sse_pkg::FADDR_RST;
            flags_r <= '0;
        end
        else
        begin
            if (to_work)
            begin
                work_r <= result;
            end
            else if (wr_work)
            begin
                work_r <= w_data_r[7:0];
            end
            if (exec && is_sub)
            begin
                flags_r <= sub_res[10:8];
            end
            else if (wr_stat && wr_all)
            begin
                flags_r <= w_data_r[2:0];
            end
            if (wr_fadr)
            begin
                faddr_r <= w_data_r[6:0];
            end
        end
    end

    // checks
    wire ex_gt = exec && is_sub && (minuend > work_r);
    wire ex_eq = exec && is_sub && (minuend == work_r);
    wire ex_lt = exec && is_sub && (minuend < work_r);
    wire [7:0] wrap_diff = minuend - work_r;
    wire lo_ge = minuend[3:0] >= work_r[3:0];
    wire [3:0] fq_lo = file_q[3:0];
    wire [3:0] fq_hi = file_q[7:4];

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    // checks the value where it lands, not the mux that forms it
    property p_swap;
        exec && is_swap |-> (!to_file || mem_wd == {fq_lo, fq_hi})
            ##1 ($past(to_file) || work_r == {$past(fq_lo), $past(fq_hi)});
    endproperty
    a_swap: assert property (p_swap) else $error("nibble exchange wrong");
    property p_dest0;
        exec && !is_lit && !ins_r.dest |-> !mem_we ##1 work_r == $past(result);
    endproperty
    a_dest0: assert property (p_dest0) else $error("dest 0 misrouted");
    property p_dest1;
        exec && !is_lit && ins_r.dest |-> mem_we && mem_wd == result
            ##1 work_r == $past(work_r);
    endproperty
    a_dest1: assert property (p_dest1) else $error("dest 1 misrouted");
    property p_gt;
        ex_gt |=> flags_r.carry && !flags_r.zero;
    endproperty
    a_gt: assert property (p_gt) else $error("positive flags wrong");
    property p_eq;
        ex_eq |=> flags_r.carry && flags_r.zero;
    endproperty
    a_eq: assert property (p_eq) else $error("zero flags wrong");
    property p_lt;
        ex_lt |-> result == wrap_diff ##1 !flags_r.carry && !flags_r.zero;
    endproperty
    a_lt: assert property (p_lt) else $error("negative flags wrong");
    property p_lit;
        exec && is_lit |=> work_r == $past(wrap_diff) && !$past(mem_we);
    endproperty
    a_lit: assert property (p_lit) else $error("literal result wrong");
    property p_dc;
        exec && is_lit |=> flags_r.digit_carry_flag == $past(lo_ge);
    endproperty
    a_dc: assert property (p_dc) else $error("digit carry wrong");
    property p_keep;
        exec && is_swap |=> flags_r == $past(flags_r);
    endproperty
    a_keep: assert property (p_keep) else $error("swap changed flags");
    property p_cycle;
        wr_ins |=> state_r == ST_FETCH ##1 state_r == ST_EXEC
            ##1 state_r == ST_IDLE;
    endproperty
    a_cycle: assert property (p_cycle) else $error("sequence length wrong");
endmodule : sse_core

// ===== src/sse_pkg.sv
package sse_pkg;
    // register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] REG_INSTR_OFS = 8'h00;
    localparam logic [7:0] REG_WORK_OFS = 8'h04;
    localparam logic [7:0] REG_STATUS_OFS = 8'h08;
    localparam logic [7:0] REG_FADDR_OFS = 8'h0c;
    localparam logic [7:0] REG_FDATA_OFS = 8'h10;
    // instruction register field positions
    localparam int INS_LIT_LSB = 0;
    localparam int INS_FADDR_LSB = 8;
    localparam int INS_DEST_BIT = 15;
    localparam int INS_OP_LSB = 16;
    // status register field positions
    localparam int ST_CARRY_BIT = 0;
    localparam int ST_DC_BIT = 1;
    localparam int ST_ZERO_BIT = 2;
    localparam int ST_BUSY_BIT = 3;
    // reset values
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [6:0] FADDR_RST = 7'h00;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // file register array
    localparam int FILE_AW = 7;
    localparam int FILE_DEPTH = 128;

    typedef enum logic [1:0] {
        OP_SUBTRACT_W_FROM_LITERAL,
        OP_SUBTRACT_W_FROM_FILE,
        OP_NIBBLE_EXCHANGE_FILE,
        OP_RESERVED
    } sse_op_e;

    typedef struct packed {
        sse_op_e op;
        logic dest;
        logic [6:0] faddr;
        logic [7:0] literal;
    } sse_instr_s;

    typedef struct packed {
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } sse_flags_s;
endpackage : sse_pkg

// ===== src/sse_file_ram.sv
`timescale 1ns/1ps
// file register array: one write port, read data come out of a register
module sse_file_ram (
    input wire logic ref_clk_i,
    input wire logic we_i,
    input wire logic [6:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [6:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_r [sse_pkg::FILE_DEPTH];

    always_ff @(posedge ref_clk_i)
    begin
        if (we_i)
        begin
            mem_r[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_r[raddr_i];
    end
endmodule : sse_file_ram

// ===== testbench/sse_axi_master.sv
`timescale 1ns/1ps
// bus master for the register side; waits carry no bound of their own,
// the bench watchdog is what ends a hang
module sse_axi_master (
    input wire logic ref_clk_i,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} <= '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} <= '0;
        s_axi_wstrb <= 4'hf;
    end

    // readies are sampled at the falling edge: nothing moves them
    // before the rising edge that takes the transfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic ha, hw, hb;
        hb = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!hb)
        begin
            @(negedge ref_clk_i);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge ref_clk_i);
            if (ha)
                s_axi_awvalid <= 1'b0;
            if (hw)
                s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        @(posedge ref_clk_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic ha, hr;
        hr = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!hr)
        begin
            @(negedge ref_clk_i);
            ha = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge ref_clk_i);
            if (ha)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        @(posedge ref_clk_i);
    endtask : rd
endmodule : sse_axi_master

// ===== testbench/test_subtract_swap_execute.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module test_subtract_swap_execute;
    localparam logic [7:0] A_INS = sse_pkg::REG_INSTR_OFS;
    localparam logic [7:0] A_WRK = sse_pkg::REG_WORK_OFS;
    localparam logic [7:0] A_ST = sse_pkg::REG_STATUS_OFS;
    localparam logic [7:0] A_FA = sse_pkg::REG_FADDR_OFS;
    localparam logic [7:0] A_FD = sse_pkg::REG_FDATA_OFS;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    int n_fail = 0;
    int tests_run = 0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [7:0] tw [4] = '{8'h01, 8'h02, 8'h03, 8'h1f};
    logic [7:0] tk [4] = '{8'h02, 8'h02, 8'h02, 8'h20};

    always #5 ref_clk_i = ~ref_clk_i;

    sse_core sse_core_inst (.ref_clk_i, .sys_rst_i, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    sse_axi_master sse_axi_master_inst (.ref_clk_i, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] rs;
        sse_axi_master_inst.wr(a, v, rs);
    endtask : wreg

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] rs;
        sse_axi_master_inst.rd(a, v, rs);
        `CHK(v, e)
    endtask : rchk

    // the note fixes two cycles of execution after the response
    task automatic ex(input sse_pkg::sse_op_e op, input logic ds,
                      input logic [6:0] fa, input logic [7:0] k);
        sse_pkg::sse_instr_s i;
        i = '{op: op, dest: ds, faddr: fa, literal: k};
        wreg(A_INS, {14'h0, i});
        repeat (3) @(posedge ref_clk_i);
    endtask : ex

    function automatic logic [31:0] fl(input logic [7:0] m,
                                       input logic [7:0] w);
        logic [7:0] df;
        df = m - w;
        return {29'h0, df == 8'h00, m[3:0] >= w[3:0], m >= w};
    endfunction : fl

    task automatic wrap_up();
        $display("compares %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        n_fail++;
        $display("ERROR %0t: watchdog expired", $time);
        wrap_up();
    end

    initial
    begin
        repeat (8) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        // dest set on purpose: the literal form must ignore it
        for (int n = 0; n < 4; n++)
        begin
            wreg(A_WRK, {24'h0, tw[n]});
            ex(sse_pkg::OP_SUBTRACT_W_FROM_LITERAL, 1'b1, 7'h00, tk[n]);
            rchk(A_WRK, {24'h0, 8'(tk[n] - tw[n])});
            rchk(A_ST, fl(tk[n], tw[n]));
        end
        wreg(A_FA, 32'h5);
        wreg(A_FD, 32'h1);
        wreg(A_WRK, 32'h2);
        ex(sse_pkg::OP_SUBTRACT_W_FROM_FILE, 1'b1, 7'h05, 8'h00);
        rchk(A_FD, 32'hff);
        rchk(A_WRK, 32'h2);
        rchk(A_ST, fl(8'h01, 8'h02));
        wreg(A_FD, 32'h2);
        ex(sse_pkg::OP_SUBTRACT_W_FROM_FILE, 1'b0, 7'h05, 8'h00);
        rchk(A_WRK, 32'h0);
        rchk(A_FD, 32'h2);
        rchk(A_ST, fl(8'h02, 8'h02));
        wreg(A_FD, 32'ha5);
        ex(sse_pkg::OP_NIBBLE_EXCHANGE_FILE, 1'b1, 7'h05, 8'h00);
        rchk(A_FD, 32'h5a);
        rchk(A_ST, 32'h7);
        rchk(A_WRK, 32'h0);
        ex(sse_pkg::OP_NIBBLE_EXCHANGE_FILE, 1'b0, 7'h05, 8'h00);
        rchk(A_WRK, 32'ha5);
        rchk(A_FD, 32'h5a);
        // spare op code: runs the sequence but touches nothing
        ex(sse_pkg::OP_RESERVED, 1'b1, 7'h05, 8'h00);
        rchk(A_WRK, 32'ha5);
        rchk(A_FD, 32'h5a);
        rchk(A_ST, 32'h7);
        sse_axi_master_inst.rd(8'h40, d, r);
        `CHK(r, sse_pkg::RESP_SLVERR)
        `CHK(d, 32'h0)
        sse_axi_master_inst.wr(8'h40, 32'h1, r);
        `CHK(r, sse_pkg::RESP_SLVERR)
        wrap_up();
    end
endmodule : test_subtract_swap_execute
